// ===== accessory_detect_status_regs.sv
// Second ADC result and first status register of the accessory detector
//
// Contract
// - Latest second converter result held as 8-bit read-only value.
// - Level field reports last detection current: none, 100uA, 1.1mA, 5.5mA.
// - Comm request reads 1 only after mic stays below threshold for debounce.
// - Open cable set when both wirings high impedance and setting is 01.
// - Ready reads 1 once detection done and mic/ground switch finalized.
// - With wiring check disabled, ready sets right after impedance detection.
// - First converter done flag: 0 idle or running, 1 when result ready.
// - Second converter done flag: 0 idle or running, 1 when result ready.
`timescale 1ns/1ps
module accessory_detect_status_regs (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Converters
  input wire logic first_adc_start,
  input wire logic first_adc_end,
  input wire logic second_adc_start,
  input wire logic second_adc_end,
  input wire logic [7:0] second_adc_data,
  // Impedance and wiring detection
  input wire logic impedance_done,
  input wire logic [1:0] detect_current_used,
  input wire logic jack_removed,
  input wire logic hi_z_first_wiring,
  input wire logic hi_z_second_wiring,
  input wire logic [1:0] detect_current_setting,
  input wire logic wiring_check_done,
  input wire logic wiring_type,
  input wire logic microphone_switch_final,
  input wire logic wiring_check_disable,
  // Button comparator
  input wire logic mic_below_threshold
);
  logic [7:0] second_adc_result_r, second_adc_result_nxt;
  logic [1:0] level_r, level_nxt;
  logic comm_r, comm_nxt;
  logic open_r, open_nxt;
  logic jack_r, jack_nxt;
  logic ready_r, ready_nxt;
  logic [accessory_status_pkg::DEB_W-1:0] deb_r, deb_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic first_adc_done, second_adc_done;
  logic [7:0] detection_status_one;

  conversion_done_flag u_first_done (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .conv_start(first_adc_start),
    .conv_done(first_adc_end),
    .done_flag(first_adc_done)
  );

  conversion_done_flag u_second_done (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .conv_start(second_adc_start),
    .conv_done(second_adc_end),
    .done_flag(second_adc_done)
  );

  always_comb begin
    detection_status_one = accessory_status_pkg::DETECTION_STATUS_ONE_RST;
    detection_status_one[accessory_status_pkg::LEVEL_HI_POS] = level_r[1];
    detection_status_one[accessory_status_pkg::LEVEL_LO_POS] = level_r[0];
    detection_status_one[accessory_status_pkg::COMM_REQ_POS] = comm_r;
    detection_status_one[accessory_status_pkg::OPEN_CABLE_POS] = open_r;
    detection_status_one[accessory_status_pkg::JACK_TYPE_POS] = jack_r;
    detection_status_one[accessory_status_pkg::READY_POS] = ready_r;
    detection_status_one[accessory_status_pkg::FIRST_DONE_POS] = first_adc_done;
    detection_status_one[accessory_status_pkg::SECOND_DONE_POS] = second_adc_done;
  end

  // Status next values; reg_wr and reg_wdata reach none of them
  always_comb begin
    second_adc_result_nxt = second_adc_result_r;
    level_nxt = level_r;
    comm_nxt = 1'b0;
    deb_nxt = deb_r;
    open_nxt = hi_z_first_wiring && hi_z_second_wiring
      && (detect_current_setting == accessory_status_pkg::OPEN_CABLE_SETTING);
    jack_nxt = jack_r;
    ready_nxt = ready_r;
    if (second_adc_end) begin
      second_adc_result_nxt = second_adc_data;
    end
    if (jack_removed) begin
      level_nxt = accessory_status_pkg::LEVEL_NO_JACK;
      ready_nxt = 1'b0;
      jack_nxt = 1'b0;
    end
    if (impedance_done) begin
      level_nxt = detect_current_used;
    end
    // Counter saturates, so a long press keeps the flag without wrapping
    if (!mic_below_threshold) begin
      deb_nxt = '0;
    end else if (deb_r != accessory_status_pkg::DEB_LAST) begin
      deb_nxt = deb_r + 8'h01;
    end
    comm_nxt = mic_below_threshold && (deb_r == accessory_status_pkg::DEB_LAST);
    if (wiring_check_done) begin
      jack_nxt = wiring_type;
    end
    // Ready set wins over a removal in the same cycle
    if (impedance_done && wiring_check_disable) begin
      ready_nxt = 1'b1;
    end
    if (wiring_check_done && microphone_switch_final) begin
      ready_nxt = 1'b1;
    end
  end

  // Read path; a write only draws no answer and changes nothing
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (reg_rd) begin
      rvalid_nxt = 1'b1;
      unique case (reg_addr)
        accessory_status_pkg::SECOND_ADC_RESULT_ADDR: rdata_nxt = second_adc_result_r;
        accessory_status_pkg::DETECTION_STATUS_ONE_ADDR: rdata_nxt = detection_status_one;
        default: rdata_nxt = accessory_status_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_adc_result_r <= accessory_status_pkg::SECOND_ADC_RESULT_RST;
      level_r <= accessory_status_pkg::LEVEL_NO_JACK;
      comm_r <= 1'b0;
      deb_r <= '0;
      open_r <= 1'b0;
      jack_r <= 1'b0;
      ready_r <= 1'b0;
      rdata_r <= accessory_status_pkg::UNMAPPED_READ_VALUE;
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      second_adc_result_r <= second_adc_result_nxt;
      level_r <= level_nxt;
      comm_r <= comm_nxt;
      deb_r <= deb_nxt;
      open_r <= open_nxt;
      jack_r <= jack_nxt;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  a_result_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && second_adc_end |=> second_adc_result_r == $past(second_adc_data))
    else $error("second result not captured");
  a_level_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && impedance_done |=> level_r == $past(detect_current_used))
    else $error("level not captured");
  a_comm_needs_press: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && !mic_below_threshold |=> !comm_r)
    else $error("comm request without press");
  a_comm_short_press: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && mic_below_threshold && deb_r == 8'h00 |=> !comm_r)
    else $error("comm request before debounce");
  a_open_cable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en |=> open_r == ($past(hi_z_first_wiring) && $past(hi_z_second_wiring)
      && $past(detect_current_setting) == accessory_status_pkg::OPEN_CABLE_SETTING))
    else $error("open cable flag wrong");
  a_ready_wiring: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && wiring_check_done && microphone_switch_final |=> ready_r)
    else $error("ready not set after wiring check");
  a_ready_direct: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && impedance_done && wiring_check_disable |=> ready_r)
    else $error("ready not set with check disabled");
  a_write_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_wr && !second_adc_end |=> $stable(second_adc_result_r))
    else $error("write changed result");
  a_read_status: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_rd && reg_addr == 8'h03 |=> reg_rdata[3] == $past(jack_r) && reg_rvalid)
    else $error("status read wrong");
  // A write must never look like a read answer, or a polling host would take stale data
  a_write_no_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_wr && !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("write drew an answer");
  a_comm_after_debounce: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && mic_below_threshold && deb_r == accessory_status_pkg::DEB_LAST |=> comm_r)
    else $error("comm request missing after debounce");
  a_ready_needs_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && !ready_r && !(wiring_check_done && microphone_switch_final)
      && !(impedance_done && wiring_check_disable) |=> !ready_r)
    else $error("ready set without a cause");
  a_removal_clears_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && jack_removed && !impedance_done
      |=> level_r == accessory_status_pkg::LEVEL_NO_JACK)
    else $error("level kept after removal");
  a_jack_capture: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && wiring_check_done |=> jack_r == $past(wiring_type))
    else $error("jack type not captured");
  a_read_result: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_rd && reg_addr == accessory_status_pkg::SECOND_ADC_RESULT_ADDR
      |=> reg_rvalid && reg_rdata == $past(second_adc_result_r))
    else $error("result read wrong");
  a_first_done_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_rd && reg_addr == accessory_status_pkg::DETECTION_STATUS_ONE_ADDR
      |=> reg_rdata[accessory_status_pkg::FIRST_DONE_POS] == $past(first_adc_done))
    else $error("first done bit read wrong");
  a_second_done_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && reg_rd && reg_addr == accessory_status_pkg::DETECTION_STATUS_ONE_ADDR
      |=> reg_rdata[accessory_status_pkg::SECOND_DONE_POS] == $past(second_adc_done))
    else $error("second done bit read wrong");
  a_result_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !clk_en |=> $stable(second_adc_result_r))
    else $error("result changed while disabled");
endmodule

// ===== accessory_detect_status_regs_tb.sv
// Testbench for the accessory detection status registers
`timescale 1ns/1ps
module accessory_detect_status_regs_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, second_adc_data = 8'h00;
  logic reg_rd, reg_wr, reg_rvalid;
  logic first_adc_start = 1'b0, first_adc_end = 1'b0;
  logic second_adc_start = 1'b0, second_adc_end = 1'b0;
  logic impedance_done = 1'b0, jack_removed = 1'b0;
  logic hi_z_first_wiring = 1'b0, hi_z_second_wiring = 1'b0;
  logic wiring_check_done = 1'b0, wiring_type = 1'b0, microphone_switch_final = 1'b0;
  logic wiring_check_disable = 1'b0, mic_below_threshold = 1'b0;
  logic [1:0] detect_current_used = 2'h0, detect_current_setting = 2'h0;
  int fail_count = 0;
  int cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  status_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  accessory_detect_status_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .first_adc_start(first_adc_start),
    .first_adc_end(first_adc_end), .second_adc_start(second_adc_start),
    .second_adc_end(second_adc_end), .second_adc_data(second_adc_data),
    .impedance_done(impedance_done), .detect_current_used(detect_current_used),
    .jack_removed(jack_removed), .hi_z_first_wiring(hi_z_first_wiring),
    .hi_z_second_wiring(hi_z_second_wiring), .detect_current_setting(detect_current_setting),
    .wiring_check_done(wiring_check_done), .wiring_type(wiring_type),
    .microphone_switch_final(microphone_switch_final),
    .wiring_check_disable(wiring_check_disable), .mic_below_threshold(mic_below_threshold));

  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    tick();
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask

  // Read and compare the whole byte, including the answer strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    cmp_count++;
    if (v !== 1'b1 || d !== e) begin
      fail_count++;
      $display("MISMATCH %0t addr %h got %h valid %b expected %h", $time, a, d, v, e);
    end
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    rchk(accessory_status_pkg::SECOND_ADC_RESULT_ADDR, 8'h00);
    rchk(accessory_status_pkg::DETECTION_STATUS_ONE_ADDR, 8'h00);
    pulse(second_adc_start);
    rchk(8'h03, 8'h00);
    second_adc_data = 8'hA5;
    pulse(second_adc_end);
    second_adc_data = 8'h5A;
    rchk(8'h02, 8'hA5);
    rchk(8'h03, 8'h01);
    pulse(first_adc_end);
    rchk(8'h03, 8'h03);
    pulse(first_adc_start);
    rchk(8'h03, 8'h01);
    host.wr(8'h02, 8'hFF);
    host.wr(8'h03, 8'hFF);
    rchk(8'h02, 8'hA5);
    rchk(8'h03, 8'h01);
    rchk(8'h10, accessory_status_pkg::UNMAPPED_READ_VALUE);
    // Each level code in turn, last one must overwrite the previous
    for (int i = 0; i < 4; i++) begin
      detect_current_used = 2'(i);
      pulse(impedance_done);
      rchk(8'h03, {2'(i), 6'h01});
    end
    pulse(jack_removed);
    rchk(8'h03, 8'h01);
    hi_z_first_wiring = 1'b1;
    hi_z_second_wiring = 1'b1;
    detect_current_setting = accessory_status_pkg::OPEN_CABLE_SETTING;
    rchk(8'h03, 8'h11);
    detect_current_setting = 2'h2;
    rchk(8'h03, 8'h01);
    detect_current_setting = 2'h1;
    hi_z_second_wiring = 1'b0;
    rchk(8'h03, 8'h01);
    // Comparator held low well short of the debounce, then past it
    mic_below_threshold = 1'b1;
    repeat (50) tick();
    rchk(8'h03, 8'h01);
    repeat (60) tick();
    rchk(8'h03, 8'h21);
    mic_below_threshold = 1'b0;
    repeat (2) tick();
    rchk(8'h03, 8'h01);
    wiring_type = 1'b1;
    pulse(wiring_check_done);
    rchk(8'h03, 8'h09);
    microphone_switch_final = 1'b1;
    pulse(wiring_check_done);
    rchk(8'h03, 8'h0D);
    pulse(jack_removed);
    rchk(8'h03, 8'h01);
    wiring_check_disable = 1'b1;
    detect_current_used = 2'h2;
    pulse(impedance_done);
    rchk(8'h03, 8'h85);
    // Events while the enable is low must be lost, not deferred
    clk_en = 1'b0;
    second_adc_data = 8'h3C;
    pulse(second_adc_end);
    pulse(first_adc_end);
    clk_en = 1'b1;
    rchk(8'h02, 8'hA5);
    rchk(8'h03, 8'h85);
    // Reset in mid-run returns every field to its reset value
    reset_n = 1'b0;
    tick();
    reset_n = 1'b1;
    rchk(8'h03, 8'h00);
    rchk(8'h02, 8'h00);
    conclude();
  end
endmodule

// ===== accessory_status_pkg.sv
// Shared constants for the accessory detection status registers
package accessory_status_pkg;
  localparam logic [7:0] SECOND_ADC_RESULT_ADDR = 8'h02;
  localparam logic [7:0] DETECTION_STATUS_ONE_ADDR = 8'h03;
  localparam logic [7:0] SECOND_ADC_RESULT_RST = 8'h00;
  localparam logic [7:0] DETECTION_STATUS_ONE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  // Field positions inside detection_status_one
  localparam int LEVEL_HI_POS = 7;
  localparam int LEVEL_LO_POS = 6;
  localparam int COMM_REQ_POS = 5;
  localparam int OPEN_CABLE_POS = 4;
  localparam int JACK_TYPE_POS = 3;
  localparam int READY_POS = 2;
  localparam int FIRST_DONE_POS = 1;
  localparam int SECOND_DONE_POS = 0;
  // Detection current level codes
  localparam logic [1:0] LEVEL_NO_JACK = 2'h0;
  localparam logic [1:0] LEVEL_100UA = 2'h1;
  localparam logic [1:0] LEVEL_1MA1 = 2'h2;
  localparam logic [1:0] LEVEL_5MA5 = 2'h3;
  localparam logic [1:0] OPEN_CABLE_SETTING = 2'h1;
  // Communication debounce
  localparam int CLK_PERIOD_NS = 10;
  localparam int COMM_DEBOUNCE_NS = 1000;
  localparam int COMM_DEBOUNCE_CYCLES = (COMM_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_W = 8;
  localparam logic [DEB_W-1:0] DEB_LAST = 8'(COMM_DEBOUNCE_CYCLES - 1);
endpackage

// ===== conversion_done_flag.sv
// End-of-conversion flag for one converter
`timescale 1ns/1ps
module conversion_done_flag (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Converter events
  input wire logic conv_start,
  input wire logic conv_done,
  // Flag
  output logic done_flag
);
  logic done_r;
  logic done_nxt;

  // Completion wins over a start in the same cycle so no result is missed
  always_comb begin
    done_nxt = done_r;
    if (conv_start) begin
      done_nxt = 1'b0;
    end
    if (conv_done) begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_r <= 1'b0;
    end else if (clk_en) begin
      done_r <= done_nxt;
    end
  end

  assign done_flag = done_r;

  a_done_follows_event: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && conv_done |=> done_flag)
    else $error("done flag not set after conversion end");
  a_start_clears_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && conv_start && !conv_done |=> !done_flag)
    else $error("done flag not cleared at conversion start");
endmodule

// ===== status_host.sv
// Host model driving the status register port
`timescale 1ns/1ps
module status_host (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'hFF;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'hFF;
  end

  // One-cycle read, answer sampled right after the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    // Idle address never mirrors the last one, so a stale decode shows up
    reg_addr = ~a;
    v = reg_rvalid;
    d = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~w;
  endtask
endmodule
